// ===== core/jtag_tdr_pkg.sv
/*
 * Constants for the boundary-scan test data registers: instruction codes,
 * register widths, identification fields, chain cell positions and the
 * capture masks.
 * Assumes a three-bit instruction register and a 129-cell boundary chain
 * whose cells are numbered 1..129, held here at vector index cell-1.
 */
package jtag_tdr_pkg;

    // ****************************************************************
    // instruction register
    // ****************************************************************
    localparam int IR_W = 3;                          // instruction width
    localparam logic [2:0] IR_EXTEST = 3'h0;          // drive pins from chain
    localparam logic [2:0] IR_IDCODE = 3'h1;          // power-up instruction
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;        // sample, read-data drivers off
    localparam logic [2:0] IR_SAMPLE = 3'h4;          // sample only
    localparam logic [2:0] IR_BYPASS = 3'h7;          // one-bit path
    localparam logic [2:0] IR_RESET_VALUE = IR_IDCODE;

    // ****************************************************************
    // identification word
    // ****************************************************************
    localparam int ID_W = 32;
    localparam logic [10:0] MFR_CODE = 11'h2A5;       // arbitrary value
    localparam logic [19:0] PART_CODE = 20'h0C0DE;    // arbitrary value
    localparam logic ID_START_BIT = 1'b1;             // bit 0 always one
    localparam logic [31:0] ID_VALUE = {PART_CODE, MFR_CODE, ID_START_BIT};

    // ****************************************************************
    // boundary chain layout
    // ****************************************************************
    localparam int CHAIN_W = 129;                     // cells 1..129
    localparam int RING_W = 128;                      // pad cells 1..128
    localparam int INTERNAL_IDX = 128;                // cell 129
    localparam logic INTERNAL_CAPTURE = 1'b1;         // captured value
    localparam int Q_W = 18;                          // read-data pins
    localparam int Q_IDX = 0;                         // cells 1..18
    localparam int VALID_IDX = 18;                    // cell 19
    localparam int ECHO_IDX = 19;                     // cells 20..21
    localparam int OUT_CELLS = 21;                    // cells 1..21
    // cells of not-connected pads capture zero (one bit set per such pad)
    localparam logic [127:0] NC_CELL_MASK = 128'h0;

    // ****************************************************************
    // reset values of state
    // ****************************************************************
    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam logic [20:0] UPDATE_RESET = 21'h0;
    localparam logic UPDATE_GATE_RESET = 1'b0;        // drivers off

endpackage : jtag_tdr_pkg

// ===== core/jtag_test_data_registers.sv
/*
 * Test data registers behind the boundary-scan port: bypass bit,
 * identification word, 129-cell boundary chain with an output update
 * latch, plus the instruction register that selects among them.
 * Assumes an external TAP state machine on the test clock that supplies
 * one-hot state strobes, and a memory core on i_ref_clk that supplies the
 * functional output values and termination request.
 */
`timescale 1ns/1ps

// Overview of operation
// RULE1: bypass capture loads zero
// RULE2: bypass bit alone on shift path
// RULE3: idcode capture loads fixed identification word
// RULE4: idcode shift connects identification word
// RULE5: id word: start bit, maker, part
// RULE6: id shifts in at 31, out 0
// RULE7: 129-cell chain captures ring levels
// RULE8: sample/extest shift connects boundary chain
// RULE9: extest drives outputs from chain cells
// RULE10: extest outputs change only at update
// RULE11: unused pins capture level, nc zero
// RULE12: internal cell 129 captures one
// RULE13: internal cell gates read-data drivers
// RULE14: termination off during extest, sample-z
// RULE15: chain shifts in at 129, out 1
// RULE16: three-bit ir, idcode preset, update-ir
// RULE17: code 010 samples and floats outputs; here only o_q_oe goes off, read-valid and echo pins stay driven
// RULE18: code 111 selects bypass
// RULE19: sample tdi rising, tdo falling
// RULE20: private codes fall back to bypass
module jtag_test_data_registers
    import jtag_tdr_pkg::*;
(
    input wire logic i_ref_clk,                     // core clock
    input wire logic i_reset_n,                     // core reset, sync
    input wire logic i_clk_en,                      // core clock enable
    input wire logic i_test_clk,                    // test clock
    input wire logic i_tdi,                         // serial in
    input wire logic i_tlr,                         // test-logic-reset state
    input wire logic i_capture_ir,                  // capture-ir state
    input wire logic i_shift_ir,                    // shift-ir state
    input wire logic i_update_ir,                   // update-ir state
    input wire logic i_capture_dr,                  // capture-dr state
    input wire logic i_shift_dr,                    // shift-dr state
    input wire logic i_update_dr,                   // update-dr state
    input wire logic [127:0] i_ring_levels,         // pad levels, cells 1..128
    input wire logic [17:0] i_core_q,               // functional read data
    input wire logic i_core_q_oe,                   // functional driver enable
    input wire logic i_core_read_valid,             // functional valid
    input wire logic [1:0] i_core_echo_clock,       // functional echo clocks
    input wire logic i_core_odt_en,                 // termination request
    output logic o_tdo,                             // serial out
    output logic o_tdo_oe,                          // serial out enable
    output logic [17:0] o_q,                        // read-data pins
    output logic o_q_oe,                            // read-data enable
    output logic o_read_valid_out,                  // read-valid pin
    output logic [1:0] o_echo_clock_out,            // echo clock pins
    output logic o_on_die_termination             // termination enable
);

    // ****************************************************************
    // test clock domain: instruction register
    // ****************************************************************
    logic [2:0] ir_shift;                           // shift stage
    logic [2:0] ir_active;                          // executing instruction

    // the shift stage reloads idcode at capture so a scan reads a pattern
    always_ff @(posedge i_test_clk) begin
        if (i_tlr || i_capture_ir) begin
            ir_shift <= IR_RESET_VALUE;             // RULE16
        end else if (i_shift_ir) begin
            ir_shift <= {i_tdi, ir_shift[2:1]};     // RULE19
        end
    end

    // a new instruction acts only from update-ir
    always_ff @(posedge i_test_clk) begin
        if (i_tlr) begin
            ir_active <= IR_RESET_VALUE;            // RULE16
        end else if (i_update_ir) begin
            ir_active <= ir_shift;                  // RULE16
        end
    end

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    wire sel_extest = (ir_active == IR_EXTEST);
    wire sel_samplez = (ir_active == IR_SAMPLE_Z);  // RULE17
    wire sel_sample = (ir_active == IR_SAMPLE);
    wire sel_idcode = (ir_active == IR_IDCODE);
    // bypass and every private code share the one-bit path
    wire sel_bypass = !(sel_extest || sel_samplez || sel_sample || sel_idcode); // RULE18 RULE20
    wire sel_chain = sel_extest || sel_samplez || sel_sample;
    wire quiet_termination = sel_extest || sel_samplez; // RULE14

    // ****************************************************************
    // bypass bit
    // ****************************************************************
    logic bypass_bit;                               // one-bit data register

    always_ff @(posedge i_test_clk) begin
        if (i_tlr) begin
            bypass_bit <= BYPASS_CAPTURE;
        end else if (sel_bypass && i_capture_dr) begin
            bypass_bit <= BYPASS_CAPTURE;           // RULE1
        end else if (sel_bypass && i_shift_dr) begin
            bypass_bit <= i_tdi;                    // RULE2
        end
    end

    // ****************************************************************
    // identification word
    // ****************************************************************
    logic [31:0] identification_word;               // serial copy of id

    always_ff @(posedge i_test_clk) begin
        if (i_tlr) begin
            identification_word <= ID_VALUE;
        end else if (sel_idcode && i_capture_dr) begin
            identification_word <= ID_VALUE;        // RULE3 RULE5
        end else if (sel_idcode && i_shift_dr) begin
            // enter at the msb, leave from the lsb
            identification_word <= {i_tdi, identification_word[31:1]}; // RULE4 RULE6
        end
    end

    // ****************************************************************
    // boundary chain capture values
    // ****************************************************************
    logic [128:0] pin_scan_chain;                   // index i is cell i+1
    logic [128:0] capture_value;                    // what capture loads

    // pad levels are taken as they stand at capture, like any boundary
    // cell; a pin moving on that edge may be read either way
    generate
        for (genvar c = 0; c < RING_W; c++) begin : g_cell
            assign capture_value[c] = NC_CELL_MASK[c] ? 1'b0 : i_ring_levels[c]; // RULE11
        end
    endgenerate
    assign capture_value[INTERNAL_IDX] = INTERNAL_CAPTURE; // RULE12

    always_ff @(posedge i_test_clk) begin
        if (i_tlr) begin
            pin_scan_chain <= '0;
        end else if (sel_chain && i_capture_dr) begin
            pin_scan_chain <= capture_value;        // RULE7
        end else if (sel_chain && i_shift_dr) begin
            pin_scan_chain <= {i_tdi, pin_scan_chain[128:1]}; // RULE8 RULE15
        end
    end

    // ****************************************************************
    // output update latch
    // ****************************************************************
    logic [20:0] update_cells;                      // cells 1..21 at update
    logic update_gate;                              // cell 129 at update
    logic update_toggle;                            // flips per update

    // shifting never disturbs the pins; only update-dr copies the cells
    always_ff @(posedge i_test_clk) begin
        if (i_tlr) begin
            update_cells <= UPDATE_RESET;
            update_gate <= UPDATE_GATE_RESET;
            update_toggle <= 1'b0;
        end else if (sel_chain && i_update_dr) begin
            update_cells <= pin_scan_chain[OUT_CELLS-1:0]; // RULE10
            update_gate <= pin_scan_chain[INTERNAL_IDX];   // RULE10
            update_toggle <= !update_toggle;
        end
    end

    // ****************************************************************
    // serial output, falling edge
    // ****************************************************************
    wire dr_out_bit = sel_bypass ? bypass_bit :
                      sel_idcode ? identification_word[0] : pin_scan_chain[0];
    wire next_tdo = (i_shift_ir || i_capture_ir) ? ir_shift[0] : dr_out_bit; // RULE16
    wire next_tdo_oe = i_shift_ir || i_shift_dr;

    // half a test clock after the rising edge, so the far end samples
    // a settled bit on its next rising edge
    always_ff @(negedge i_test_clk) begin
        if (i_tlr) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo <= next_tdo;                      // RULE19
            o_tdo_oe <= next_tdo_oe;                // RULE19
        end
    end

    // ****************************************************************
    // crossing into the core clock
    // ****************************************************************
    logic [2:0] extest_sync;                        // mode, 3 stages
    logic [2:0] quiet_sync;                         // termination off
    logic [2:0] samplez_sync;                       // drivers off
    logic [2:0] toggle_sync;                        // update event
    logic extest_ref;                               // agreed extest
    logic quiet_ref;                                // agreed quiet
    logic samplez_ref;                              // agreed sample-z
    logic toggle_seen;                              // last toggle taken
    logic [20:0] cells_ref;                         // core copy of latch
    logic gate_ref;                                 // core copy of gate

    // a change counts only once stages two and three agree
    wire extest_agree = (extest_sync[1] == extest_sync[2]);
    wire quiet_agree = (quiet_sync[1] == quiet_sync[2]);
    wire samplez_agree = (samplez_sync[1] == samplez_sync[2]);
    wire toggle_agree = (toggle_sync[1] == toggle_sync[2]);
    // latch words are stable for several test clocks after an update,
    // longer than this handshake needs, so they are read directly
    wire take_cells = toggle_agree && (toggle_sync[2] != toggle_seen);

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            extest_sync <= 3'h0;
            quiet_sync <= 3'h0;
            samplez_sync <= 3'h0;
            toggle_sync <= 3'h0;
        end else if (i_clk_en) begin
            extest_sync <= {extest_sync[1:0], sel_extest};
            quiet_sync <= {quiet_sync[1:0], quiet_termination};
            samplez_sync <= {samplez_sync[1:0], sel_samplez};
            toggle_sync <= {toggle_sync[1:0], update_toggle};
        end
    end

    // agreed modes and latched cell copy
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            extest_ref <= 1'b0;
            quiet_ref <= 1'b0;
            samplez_ref <= 1'b0;
            toggle_seen <= 1'b0;
            cells_ref <= UPDATE_RESET;
            gate_ref <= UPDATE_GATE_RESET;
        end else if (i_clk_en) begin
            if (extest_agree) extest_ref <= extest_sync[2];
            if (quiet_agree) quiet_ref <= quiet_sync[2];
            if (samplez_agree) samplez_ref <= samplez_sync[2];
            if (take_cells) begin
                toggle_seen <= toggle_sync[2];
                cells_ref <= update_cells;          // RULE10
                gate_ref <= update_gate;
            end
        end
    end

    // ****************************************************************
    // output pins
    // ****************************************************************
    wire [17:0] next_q = extest_ref ? cells_ref[Q_IDX +: Q_W] : i_core_q; // RULE9
    // cell 129 decides the drivers under extest; sample-z floats them
    wire next_q_oe = extest_ref ? gate_ref : (i_core_q_oe && !samplez_ref); // RULE13 RULE17
    wire next_valid = extest_ref ? cells_ref[VALID_IDX] : i_core_read_valid; // RULE9
    wire [1:0] next_echo = extest_ref ? cells_ref[ECHO_IDX +: 2] : i_core_echo_clock; // RULE9
    wire next_odt = i_core_odt_en && !quiet_ref;    // RULE14

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_q <= '0;
            o_q_oe <= 1'b0;
            o_read_valid_out <= 1'b0;
            o_echo_clock_out <= 2'h0;
            o_on_die_termination <= 1'b0;
        end else if (i_clk_en) begin
            o_q <= next_q;
            o_q_oe <= next_q_oe;
            o_read_valid_out <= next_valid;
            o_echo_clock_out <= next_echo;
            o_on_die_termination <= next_odt;
        end
    end

    // ****************************************************************
    // checks, test clock domain
    // ****************************************************************
    sequence s_bsr_capture;
        sel_chain && i_capture_dr;
    endsequence

    sequence s_bsr_shift;
        sel_chain && i_shift_dr && !i_tlr;
    endsequence

    chk_bypass_capture_zero: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE1
        sel_bypass && i_capture_dr |=> (bypass_bit == 1'b0))
        else $error("bypass bit not zero after capture");

    chk_bypass_shift_path: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE2
        sel_bypass && i_shift_dr ##1 i_shift_dr |-> (bypass_bit == $past(i_tdi)))
        else $error("bypass bit did not take tdi");

    chk_id_capture_value: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE3
        sel_idcode && i_capture_dr |=> (identification_word == ID_VALUE) && identification_word[0])
        else $error("id word wrong after capture");

    chk_id_shift_order: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE6
        sel_idcode && i_shift_dr |=>
        (identification_word == {$past(i_tdi), $past(identification_word[31:1])}))
        else $error("id word shifted wrongly");

    chk_internal_cell_one: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE12
        s_bsr_capture |=> pin_scan_chain[INTERNAL_IDX])
        else $error("internal cell did not capture one");

    chk_chain_shift_order: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE15
        s_bsr_shift |=> (pin_scan_chain[128] == $past(i_tdi))
        && (pin_scan_chain[127:0] == $past(pin_scan_chain[128:1])))
        else $error("chain shifted wrongly");

    chk_update_hold_cells: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE10
        !i_update_dr |=> $stable(update_cells) && $stable(update_gate))
        else $error("update latch moved outside update-dr");

    chk_ir_idcode_preset: assert property (@(posedge i_test_clk) disable iff (i_tlr) // RULE16
        i_capture_ir ##1 !i_update_ir |-> (ir_shift == IR_IDCODE) && $stable(ir_active))
        else $error("instruction preset or hold wrong");

    // ****************************************************************
    // checks, core clock domain
    // ****************************************************************
    chk_extest_gate_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE13
        i_clk_en && extest_ref && !gate_ref |=> !o_q_oe)
        else $error("read-data drivers on with cell 129 low");

    chk_termination_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE14
        i_clk_en && quiet_ref |=> !o_on_die_termination)
        else $error("termination on during extest or sample-z");

    chk_extest_pin_copy: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE9
        i_clk_en && extest_ref |=> (o_read_valid_out == $past(cells_ref[VALID_IDX])))
        else $error("read-valid pin not from chain cell");

endmodule : jtag_test_data_registers

// ===== verification/jtag_ctrl_model.sv
/* external test controller model: steps the tap strobes, drives tdi and samples tdo.
   assumes a test clock from the bench and one scan in flight at a time. */
`timescale 1ns/1ps
module jtag_ctrl_model (
    input wire logic i_test_clk,
    input wire logic i_tdo,
    output logic o_tdi,
    output logic o_tlr,
    output logic o_capture_ir,
    output logic o_shift_ir,
    output logic o_update_ir,
    output logic o_capture_dr,
    output logic o_shift_dr,
    output logic o_update_dr
);
    // idle levels from time zero; test logic held in reset until reset_tap releases it
    initial begin
        {o_tdi, o_tlr, o_capture_ir, o_shift_ir, o_update_ir} = 5'h8;
        {o_capture_dr, o_shift_dr, o_update_dr} = 3'h0;
    end
    // five cycles in test-logic-reset, as a real controller gives
    task automatic reset_tap();
        @(negedge i_test_clk) o_tlr <= 1'b1;
        repeat (5) @(negedge i_test_clk);
        o_tlr <= 1'b0;
    endtask : reset_tap
    // capture, len shifts lsb first, optional update; len 0 gives an update alone
    task automatic scan(input logic ir, input int len, input logic [128:0] din, input logic upd,
                        output logic [128:0] dout);
        dout = '0;
        @(negedge i_test_clk);
        o_capture_ir <= ir & (len > 0);
        o_capture_dr <= ~ir & (len > 0);
        for (int i = 0; i < len; i++) begin
            @(negedge i_test_clk); // change away from the sampling edge
            o_capture_ir <= 1'b0;
            o_capture_dr <= 1'b0;
            o_shift_ir <= ir;
            o_shift_dr <= ~ir;
            o_tdi <= din[i];
            @(posedge i_test_clk);
            dout[i] = i_tdo; // launched on the previous falling edge
        end
        @(negedge i_test_clk);
        {o_shift_ir, o_shift_dr} <= 2'h0;
        o_tdi <= ~o_tdi; // released line must not show a stale bit
        o_update_ir <= ir & upd;
        o_update_dr <= ~ir & upd;
        @(negedge i_test_clk);
        o_update_ir <= 1'b0;
        o_update_dr <= 1'b0;
    endtask : scan
endmodule : jtag_ctrl_model

// ===== verification/jtag_test_data_registers_tb_top.sv
/* bench top: core and test clocks, controller model, random core traffic.
   assumes the controller model owns every tap strobe of the device. */
`timescale 1ns/1ps
module jtag_test_data_registers_tb_top;
    import jtag_tdr_pkg::*;
    logic i_ref_clk, i_reset_n, i_clk_en, i_test_clk, i_tdi, i_tlr;
    logic i_capture_ir, i_shift_ir, i_update_ir, i_capture_dr, i_shift_dr, i_update_dr;
    logic [127:0] i_ring_levels;
    logic [17:0] i_core_q, o_q;
    logic i_core_q_oe, i_core_read_valid, i_core_odt_en;
    logic [1:0] i_core_echo_clock, o_echo_clock_out;
    logic o_tdo, o_tdo_oe, o_q_oe, o_read_valid_out, o_on_die_termination;
    int bad_count = 0;
    int compares = 0;
    int seed = 45800;
    logic [128:0] din, dout, latch; // latch mirrors the update stage
    logic [2:0] codes [8] = '{IR_BYPASS, 3'h3, 3'h5, 3'h6, IR_SAMPLE, IR_SAMPLE_Z, IR_EXTEST, IR_EXTEST};

    jtag_test_data_registers u_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
        .i_test_clk(i_test_clk), .i_tdi(i_tdi), .i_tlr(i_tlr), .i_capture_ir(i_capture_ir),
        .i_shift_ir(i_shift_ir), .i_update_ir(i_update_ir), .i_capture_dr(i_capture_dr),
        .i_shift_dr(i_shift_dr), .i_update_dr(i_update_dr), .i_ring_levels(i_ring_levels),
        .i_core_q(i_core_q), .i_core_q_oe(i_core_q_oe), .i_core_read_valid(i_core_read_valid),
        .i_core_echo_clock(i_core_echo_clock), .i_core_odt_en(i_core_odt_en), .o_tdo(o_tdo),
        .o_tdo_oe(o_tdo_oe), .o_q(o_q), .o_q_oe(o_q_oe), .o_read_valid_out(o_read_valid_out),
        .o_echo_clock_out(o_echo_clock_out), .o_on_die_termination(o_on_die_termination));
    jtag_ctrl_model u_ctrl (.i_test_clk(i_test_clk), .i_tdo(o_tdo), .o_tdi(i_tdi), .o_tlr(i_tlr),
        .o_capture_ir(i_capture_ir), .o_shift_ir(i_shift_ir), .o_update_ir(i_update_ir),
        .o_capture_dr(i_capture_dr), .o_shift_dr(i_shift_dr), .o_update_dr(i_update_dr));

    // ****************************************************************
    // clocks: test clock offset so the domains share no phase
    // ****************************************************************
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_test_clk = 1'b0;
        #7;
        forever #15 i_test_clk = ~i_test_clk;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        final_report();
    end

    task automatic check(input logic [128:0] seen, input logic [128:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // new pad levels and functional values; termination request kept on
    task automatic core_rand();
        @(posedge i_ref_clk);
        i_ring_levels <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        {i_core_q, i_core_q_oe, i_core_read_valid, i_core_odt_en, i_core_echo_clock} <= 23'($random(seed)) | 23'h4;
        repeat (3) @(posedge i_ref_clk);
    endtask : core_rand
    // pins after the mode has settled; q floats under sample-z, so q, read-valid and echo are skipped there
    task automatic core_check(input logic [2:0] mode, input logic [128:0] lat);
        logic ext;
        logic hiz;
        ext = (mode === IR_EXTEST);
        hiz = (mode === IR_SAMPLE_Z);
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        check(o_on_die_termination, i_core_odt_en & ~(ext | hiz));
        check(o_tdo_oe, 1'b0);
        check(o_q_oe, ext ? lat[128] : (hiz ? 1'b0 : i_core_q_oe));
        if (!hiz) check({o_echo_clock_out, o_read_valid_out, o_q},
            ext ? lat[20:0] : {i_core_echo_clock, i_core_read_valid, i_core_q});
    endtask : core_check

    initial begin
        i_reset_n = 1'b0;
        i_clk_en = 1'b1;
        i_ring_levels = '0;
        {i_core_q, i_core_q_oe, i_core_read_valid, i_core_odt_en, i_core_echo_clock} = '0;
        latch = '0;
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        u_ctrl.reset_tap();
        core_rand();
        core_check(IR_IDCODE, latch);
        din = 129'($random(seed));
        u_ctrl.scan(1'b0, 32, din, 1'b1, dout);
        check(dout, 129'(ID_VALUE));
        $display("test idcode done");
        for (int i = 0; i < 8; i++) begin
            din = 129'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
            u_ctrl.scan(1'b1, 3, 129'(codes[i]), 1'b1, dout);
            check(dout[2:0], IR_IDCODE);
            core_rand();
            if (i < 4) begin
                u_ctrl.scan(1'b0, 8, din, 1'b1, dout);
                check(dout[7:0], {din[6:0], 1'b0});
                core_check(codes[i], latch);
            end else begin
                din[128] = i[0];
                u_ctrl.scan(1'b0, 129, din, 1'b0, dout);
                check(dout, {1'b1, i_ring_levels & ~NC_CELL_MASK});
                core_check(codes[i], latch);
                u_ctrl.scan(1'b0, 0, din, 1'b1, dout);
                latch = din;
                core_check(codes[i], latch);
            end
            $display("test code %h done", codes[i]);
        end
        final_report();
    end
endmodule : jtag_test_data_registers_tb_top
